/* rtl/gpp_pkg.sv */
// gpp_pkg: constants and types shared by the general purpose port block
package gpp_pkg;
  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned GPP_WIDTH    = 8;
  localparam logic [7:0]  GPP_DATA_RST = 8'hff;
  localparam logic [7:0]  GPP_CFG_RST  = 8'h00;
  localparam logic [2:0]  GPP_CFG_BITS_RST = 3'h0;

  // ----------------------------------------------------------------
  // configuration codes {hi,mid,lo}
  // ----------------------------------------------------------------
  localparam logic [2:0] GPP_CFG_BID_WP  = 3'h0;
  localparam logic [2:0] GPP_CFG_IN_CMOS = 3'h1;
  localparam logic [2:0] GPP_CFG_OUT_PP  = 3'h2;
  localparam logic [2:0] GPP_CFG_AF_PP   = 3'h3;
  localparam logic [2:0] GPP_CFG_BID_OD  = 3'h4;
  localparam logic [2:0] GPP_CFG_IN_TTL  = 3'h5;
  localparam logic [2:0] GPP_CFG_OUT_OD  = 3'h6;
  localparam logic [2:0] GPP_CFG_AF_OD   = 3'h7;

  // pin mode, Gray-coded along bid -> out -> in -> altfn
  typedef enum logic [1:0] {
    GPP_BIDIR = 2'h0,
    GPP_OUT   = 2'h1,
    GPP_IN    = 2'h3,
    GPP_ALTFN = 2'h2
  } gpp_mode_t;

  // input threshold selection reported to the pad
  typedef enum logic [1:0] {
    GPP_THR_TTL    = 2'h0,
    GPP_THR_CMOS   = 2'h1,
    GPP_THR_SCHMIT = 2'h3,
    GPP_THR_ANALOG = 2'h2
  } gpp_thr_t;
endpackage

/* rtl/gpp_bit_decode.sv */
// gpp_bit_decode: per-bit configuration decoder of the port
`timescale 1ns/1ns
`default_nettype none
module gpp_bit_decode
  import gpp_pkg::*;
(
  // configuration
  input  wire logic [2:0] cfg,
  input  wire logic       isAnalogPin,
  input  wire logic       isSchmittPin,
  input  wire logic       hasPullup,
  // decoded attributes
  output gpp_mode_t       mode,
  output logic            pushPull,
  output logic            weakPullup,
  output logic            driverOff,
  output gpp_thr_t        threshold
);
  // mode from the low two bits, the high bit chooses drive style, or the threshold in input mode
  always_comb begin
    case (cfg[1:0])
      2'h0:    mode = GPP_BIDIR;
      2'h2:    mode = GPP_OUT;
      2'h1:    mode = GPP_IN;
      2'h3:    mode = GPP_ALTFN;
      default: mode = GPP_BIDIR;
    endcase
  end

  // drive style: only 010 and 011 push-pull; 000 adds the weak pull-up
  always_comb begin
    pushPull   = (cfg == GPP_CFG_OUT_PP) || (cfg == GPP_CFG_AF_PP);
    weakPullup = (cfg == GPP_CFG_BID_WP) && hasPullup && !isAnalogPin;
    driverOff  = (cfg[1:0] == 2'h1) || isAnalogPin;
  end

  // threshold: cmos only for 001, schmitt pads have no choice
  always_comb begin
    if (isAnalogPin) begin
      threshold = GPP_THR_ANALOG;
    end else if (isSchmittPin) begin
      threshold = GPP_THR_SCHMIT;
    end else if (cfg == GPP_CFG_IN_CMOS) begin
      threshold = GPP_THR_CMOS;
    end else begin
      threshold = GPP_THR_TTL;
    end
  end
endmodule
`default_nettype wire

/* rtl/gpp_port.sv */
// gpp_port: eight-bit general purpose port with configurable pin modes
`timescale 1ns/1ns
`default_nettype none
module gpp_port
  import gpp_pkg::*;
#(
  parameter int unsigned NALT = 2,
  parameter logic [7:0] ANALOG_PINS  = 8'h00,
  parameter logic [7:0] SCHMITT_PINS = 8'h00,
  parameter logic [7:0] PULLUP_PINS  = 8'hff,
  parameter logic [7:0] ALT_PRESENT  = 8'h00
)(
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                resetn,
  // cpu register access and instruction timing
  input  wire logic                dataWrite,
  input  wire logic [2:0]          cfgWrite,
  input  wire logic [7:0]          writeData,
  input  wire logic                instrStart,
  input  wire logic                instrEnd,
  // low power modes
  input  wire logic                idleWaitMode,
  input  wire logic                haltMode,
  input  wire logic                clkOutRun,
  // peripherals
  input  wire logic [NALT*8-1:0]   altOut,
  input  wire logic [7:0]          altLoad,
  // pads
  input  wire logic [7:0]          padIn,
  // read-back
  output logic      [7:0]          portRead,
  output logic      [7:0]          cfgSelectLo,
  output logic      [7:0]          cfgSelectMid,
  output logic      [7:0]          cfgSelectHi,
  // alternate inputs and converter
  output logic      [7:0]          altIn,
  output logic      [7:0]          analogRoute,
  // pad controls
  output logic      [7:0]          padOut,
  output logic      [7:0]          padOe,
  output logic      [7:0]          padPullup,
  output logic      [15:0]         padThreshold,
  output logic                     clkOutEn
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] portDataReg_q;
  logic [7:0] slave_q;
  logic [7:0] inLatch_q;
  logic [7:0] cfgLo_q;
  logic [7:0] cfgMid_q;
  logic [7:0] cfgHi_q;
  logic [7:0] padOut_q;
  logic [7:0] padOe_q;
  logic [7:0] padPull_q;
  logic [15:0] thr_q;
  logic [7:0] altIn_q;
  logic [7:0] anaRoute_q;
  logic       clkOutEn_q;

  gpp_mode_t  bitMode   [8];
  logic [7:0] bitPp;
  logic [7:0] bitWp;
  logic [7:0] bitOff;
  gpp_thr_t   bitThr    [8];
  logic [7:0] altAnd;
  logic [7:0] drvVal_d;
  logic [7:0] drvOe_d;

  // and-combine all peripheral outputs of one bit
  function automatic logic [7:0] and_alts(input logic [NALT*8-1:0] v);
    logic [7:0] r;
    r = 8'hff;
    for (int k = 0; k < NALT; k++) begin
      r = r & v[k*8 +: 8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // per-bit decoders
  // ----------------------------------------------------------------
  for (genvar n = 0; n < GPP_WIDTH; n++) begin : g_dec
    gpp_bit_decode u_dec (
      .cfg          ({cfgHi_q[n], cfgMid_q[n], cfgLo_q[n]}),
      .isAnalogPin  (ANALOG_PINS[n]),
      .isSchmittPin (SCHMITT_PINS[n]),
      .hasPullup    (PULLUP_PINS[n]),
      .mode         (bitMode[n]),
      .pushPull     (bitPp[n]),
      .weakPullup   (bitWp[n]),
      .driverOff    (bitOff[n]),
      .threshold    (bitThr[n])
    );
  end

  // unconnected alternate outputs read as 1 so the pin idles high
  assign altAnd = and_alts(altOut) | ~ALT_PRESENT;

  // ----------------------------------------------------------------
  // configuration and data registers
  // ----------------------------------------------------------------
  // writes land in the master latch whatever the mode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      portDataReg_q <= GPP_DATA_RST;
    end else if (dataWrite) begin
      portDataReg_q <= writeData;
    end
  end

  // control registers, one write strobe each
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfgLo_q  <= GPP_CFG_RST;
      cfgMid_q <= GPP_CFG_RST;
      cfgHi_q  <= GPP_CFG_RST;
    end else begin
      if (cfgWrite[0]) begin
        cfgLo_q <= writeData;
      end
      if (cfgWrite[1]) begin
        cfgMid_q <= writeData;
      end
      if (cfgWrite[2]) begin
        cfgHi_q <= writeData;
      end
    end
  end

  // ----------------------------------------------------------------
  // slave and input latches
  // ----------------------------------------------------------------
  // slave: master at instruction end, or peripheral strobe in altfn mode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      slave_q <= GPP_DATA_RST;
    end else begin
      for (int n = 0; n < GPP_WIDTH; n++) begin
        if (bitMode[n] == GPP_ALTFN) begin
          if (altLoad[n] || !ALT_PRESENT[n]) begin
            slave_q[n] <= altAnd[n] | ANALOG_PINS[n];
          end
        end else if (instrEnd) begin
          slave_q[n] <= portDataReg_q[n];
        end
      end
    end
  end

  // input latch: pin at start, master at end in output mode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      inLatch_q <= GPP_DATA_RST;
    end else begin
      for (int n = 0; n < GPP_WIDTH; n++) begin
        if (bitMode[n] == GPP_OUT) begin
          if (instrEnd) begin
            inLatch_q[n] <= portDataReg_q[n];
          end
        end else if (instrStart) begin
          inLatch_q[n] <= padIn[n];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pad drive
  // ----------------------------------------------------------------
  // open-drain enables the driver only for a zero
  always_comb begin
    for (int n = 0; n < GPP_WIDTH; n++) begin
      drvVal_d[n] = slave_q[n];
      if (bitOff[n]) begin
        drvOe_d[n] = 1'b0;
      end else if (bitPp[n]) begin
        drvOe_d[n] = 1'b1;
      end else begin
        drvOe_d[n] = !slave_q[n];
      end
    end
  end

  // pad registers; low power modes leave the pins untouched
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      padOut_q  <= GPP_DATA_RST;
      padOe_q   <= GPP_CFG_RST;
      padPull_q <= PULLUP_PINS & ~ANALOG_PINS;
      thr_q     <= 16'h0000;
    end else begin
      padOut_q  <= drvVal_d;
      padOe_q   <= drvOe_d;
      padPull_q <= bitWp;
      for (int n = 0; n < GPP_WIDTH; n++) begin
        thr_q[n*2 +: 2] <= bitThr[n];
      end
    end
  end

  // ----------------------------------------------------------------
  // alternate inputs, converter route and clock outputs
  // ----------------------------------------------------------------
  // driven pins echo their own value so the alt input sees the output
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      altIn_q    <= GPP_DATA_RST;
      anaRoute_q <= GPP_CFG_RST;
    end else begin
      for (int n = 0; n < GPP_WIDTH; n++) begin
        altIn_q[n] <= padOe_q[n] ? padOut_q[n] : padIn[n];
        anaRoute_q[n] <= ANALOG_PINS[n] && (bitMode[n] == GPP_ALTFN) &&
                         cfgHi_q[n];
      end
    end
  end

  // clock outputs run in wait mode and stop in halt mode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clkOutEn_q <= 1'b0;
    end else begin
      clkOutEn_q <= clkOutRun && !haltMode;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign portRead     = inLatch_q;
  assign cfgSelectLo  = cfgLo_q;
  assign cfgSelectMid = cfgMid_q;
  assign cfgSelectHi  = cfgHi_q;
  assign altIn        = altIn_q;
  assign analogRoute  = anaRoute_q;
  assign padOut       = padOut_q;
  assign padOe        = padOe_q;
  assign padPullup    = padPull_q;
  assign padThreshold = thr_q;
  assign clkOutEn     = clkOutEn_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // wait mode needs no logic of its own: pins simply keep their state
  property p_od_zero_only;
    @(posedge mclk) disable iff (!resetn)
    (padOe & padOut & ~$past(bitPp)) == 8'h00;
  endproperty
  a_od_zero_only: assert property (p_od_zero_only) else $error("open-drain drove high");

  property p_write_master;
    @(posedge mclk) disable iff (!resetn)
    dataWrite |=> portDataReg_q == $past(writeData);
  endproperty
  a_write_master: assert property (p_write_master) else $error("write lost");

  property p_read_latch;
    @(posedge mclk) disable iff (!resetn)
    instrStart && !dataWrite && cfgWrite == 3'h0 && bitMode[0] == GPP_BIDIR |=> portRead[0] == $past(padIn[0]);
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("bid read not pin");

  property p_out_end;
    @(posedge mclk) disable iff (!resetn)
    instrEnd && bitMode[0] == GPP_OUT |=> slave_q[0] == $past(portDataReg_q[0]) && inLatch_q[0] == $past(portDataReg_q[0]);
  endproperty
  a_out_end: assert property (p_out_end) else $error("output copy missed");

  property p_in_tristate;
    @(posedge mclk) disable iff (!resetn)
    bitMode[1] == GPP_IN |=> !padOe[1];
  endproperty
  a_in_tristate: assert property (p_in_tristate) else $error("input drove pin");

  property p_halt_clk;
    @(posedge mclk) disable iff (!resetn)
    haltMode |=> !clkOutEn;
  endproperty
  a_halt_clk: assert property (p_halt_clk) else $error("clock out in halt");

  property p_wait_clk;
    @(posedge mclk) disable iff (!resetn)
    idleWaitMode && clkOutRun && !haltMode |=> clkOutEn;
  endproperty
  a_wait_clk: assert property (p_wait_clk) else $error("clock out stopped in wait");

  property p_echo;
    @(posedge mclk) disable iff (!resetn)
    padOe[2] |=> altIn[2] == $past(padOut[2]);
  endproperty
  a_echo: assert property (p_echo) else $error("alt input lost output");

  property p_pp_on;
    @(posedge mclk) disable iff (!resetn)
    bitPp[3] && !bitOff[3] |=> padOe[3];
  endproperty
  a_pp_on: assert property (p_pp_on) else $error("push-pull not driving");
endmodule
`default_nettype wire

/* verif/gpp_pad_model.sv */
// gpp_pad_model: pin wires and external drivers seen by the port's pads
`timescale 1ns/1ns
`default_nettype none
module gpp_pad_model (
  // clock
  input  wire logic       mclk,
  // port side pad controls
  input  wire logic [7:0] padOut,
  input  wire logic [7:0] padOe,
  input  wire logic [7:0] padPullup,
  // external drivers commanded by the bench
  input  wire logic [7:0] extVal,
  input  wire logic [7:0] extOe,
  // resolved pin level
  output logic      [7:0] padIn
);
  logic [7:0] flt = 8'h55;
  // an undriven pin without pull-up wanders, so nothing may lean on a stale level
  always @(posedge mclk) begin
    flt <= ~flt;
  end
  // wired-and of both drivers; the pull-up only counts when nobody drives
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (padOe[i] || extOe[i]) begin
        padIn[i] = (~padOe[i] | padOut[i]) & (~extOe[i] | extVal[i]);
      end else begin
        padIn[i] = padPullup[i] ? 1'b1 : flt[i];
      end
    end
  end
endmodule
`default_nettype wire

/* verif/gpp_port_tb.sv */
// gpp_port_tb: self-checking bench of the eight-bit general purpose port
`timescale 1ns/1ns
`default_nettype none
module gpp_port_tb;
  import gpp_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0, resetn = 1'b0, dataWrite = 1'b0, instrStart = 1'b0, instrEnd = 1'b0;
  logic idleWaitMode = 1'b0, haltMode = 1'b0, clkOutRun = 1'b0;
  logic [2:0] cfgWrite = 3'h0;
  logic [7:0] writeData = 8'h00, altLoad = 8'h00, extVal = 8'h00, extOe = 8'h00, padIn;
  logic [15:0] altOut = 16'hffff, padThreshold;
  logic [7:0] portRead, cfgSelectLo, cfgSelectMid, cfgSelectHi, altIn, analogRoute;
  logic [7:0] padOut, padOe, padPullup;
  logic clkOutEn;
  int n_errors = 0, samples_checked = 0;

  // pin 7 hardwired analogue, pin 6 schmitt, pin 0 without pull-up, pins 3..0 with peripheral
  gpp_port #(.NALT(2), .ANALOG_PINS(8'h80), .SCHMITT_PINS(8'h40), .PULLUP_PINS(8'hfe),
    .ALT_PRESENT(8'h0f)) gpp_port_inst (.mclk(mclk), .resetn(resetn), .dataWrite(dataWrite),
    .cfgWrite(cfgWrite), .writeData(writeData), .instrStart(instrStart), .instrEnd(instrEnd),
    .idleWaitMode(idleWaitMode), .haltMode(haltMode), .clkOutRun(clkOutRun), .altOut(altOut),
    .altLoad(altLoad), .padIn(padIn), .portRead(portRead), .cfgSelectLo(cfgSelectLo),
    .cfgSelectMid(cfgSelectMid), .cfgSelectHi(cfgSelectHi), .altIn(altIn),
    .analogRoute(analogRoute), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
    .padThreshold(padThreshold), .clkOutEn(clkOutEn));
  gpp_pad_model gpp_pad_model_inst (.mclk(mclk), .padOut(padOut), .padOe(padOe),
    .padPullup(padPullup), .extVal(extVal), .extOe(extOe), .padIn(padIn));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    forever #2 mclk = ~mclk;
  end
  // return just after the edge so the design's updates have landed before any check
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle strobe, then an idle edge so back-to-back calls never collide
  task automatic strobe(input int which, input logic [7:0] d);
    @(posedge mclk);
    writeData <= d;
    case (which)
      0: dataWrite <= 1'b1;
      1: instrStart <= 1'b1;
      2: instrEnd <= 1'b1;
      3: altLoad <= d;
      default: cfgWrite <= 3'h1 << (which - 4);
    endcase
    @(posedge mclk);
    {dataWrite, instrStart, instrEnd, altLoad, cfgWrite} <= '0;
    @(posedge mclk);
  endtask
  task automatic set_code(input logic [2:0] c);
    for (int i = 0; i < 3; i++) strobe(4 + i, {8{c[i]}});
    tick(3);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check("portRead", portRead, GPP_DATA_RST);
    check("cfgHi", {cfgSelectHi, cfgSelectMid}, 16'h0000);
    check("cfgLo", cfgSelectLo, GPP_CFG_RST);
    check("padOe", padOe, 8'h00);
    check("padPullup", padPullup, 8'h7e);
    check("altIn", altIn, 8'hff);
    check("clkOutEn", clkOutEn, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_output;
    set_code(GPP_CFG_OUT_PP);
    @(posedge mclk);
    extOe <= 8'hff;
    extVal <= 8'hff;
    strobe(0, 8'h5a);
    strobe(2, 8'h00);
    tick(2);
    check("pp padOut", padOut & 8'h7f, 8'h5a);
    check("pp padOe", padOe & 8'h7f, 8'h7f);
    check("out portRead", portRead & 8'h7f, 8'h5a);
    check("cfg hi mid", {cfgSelectHi, cfgSelectMid}, 16'h00ff);
    @(posedge mclk);
    extOe <= 8'h00;
    set_code(GPP_CFG_OUT_OD);
    strobe(0, 8'h0f);
    strobe(2, 8'h00);
    tick(2);
    check("od padOe", padOe & 8'h7f, 8'h70);
    $display("test output done");
  endtask
  task automatic t_bidir;
    set_code(GPP_CFG_BID_WP);
    @(posedge mclk);
    extOe <= 8'h0f;
    extVal <= 8'h03;
    strobe(2, 8'h00);
    strobe(1, 8'h00);
    tick(2);
    check("bid pullup", padPullup & 8'h7f, 8'h7e);
    check("bid portRead", portRead & 8'h7f, 8'h03);
    // modify a working copy, then load the whole port at once
    strobe(0, 8'h0f | 8'h80);
    strobe(2, 8'h00);
    tick(2);
    check("bid padOe", padOe & 8'h7f, 8'h70);
    @(posedge mclk);
    extOe <= 8'h00;
    $display("test bidir done");
  endtask
  task automatic t_input;
    set_code(GPP_CFG_IN_CMOS);
    @(posedge mclk);
    extOe <= 8'hff;
    extVal <= 8'ha5;
    strobe(1, 8'h00);
    tick(2);
    check("in portRead", portRead & 8'h7f, 8'h25);
    check("in padOe", padOe & 8'h7f, 8'h00);
    check("cmos thr", padThreshold & 16'h3fff, 16'h3555);
    check("in altIn", altIn & 8'h7f, 8'h25);
    strobe(0, 8'h3c);
    strobe(2, 8'h00);
    set_code(GPP_CFG_IN_TTL);
    check("ttl thr", padThreshold & 16'h3fff, 16'h3000);
    @(posedge mclk);
    extOe <= 8'h00;
    set_code(GPP_CFG_OUT_PP);
    check("late padOut", padOut & 8'h7f, 8'h3c);
    $display("test input done");
  endtask
  task automatic t_altfn;
    set_code(GPP_CFG_AF_PP);
    @(posedge mclk);
    altOut <= {8'h05, 8'hff};
    strobe(3, 8'hff);
    tick(2);
    check("af padOut", padOut & 8'h7f, 8'h75);
    check("af padOe", padOe & 8'h7f, 8'h7f);
    check("af altIn", altIn & 8'h7f, 8'h75);
    set_code(GPP_CFG_AF_OD);
    @(posedge mclk);
    altOut <= {8'hff, 8'hfa};
    strobe(3, 8'hff);
    tick(2);
    check("afod padOe", padOe, 8'h05);
    check("analogRoute", analogRoute, 8'h80);
    check("analog thr", padThreshold[15:14], 2'h2);
    check("analog forced", padOut[7], 1'b1);
    $display("test altfn done");
  endtask
  task automatic t_lowpower;
    @(posedge mclk);
    clkOutRun <= 1'b1;
    idleWaitMode <= 1'b1;
    tick(3);
    check("wait clk", clkOutEn, 1'b1);
    check("wait padOe", padOe, 8'h05);
    @(posedge mclk);
    haltMode <= 1'b1;
    tick(3);
    check("halt clk", clkOutEn, 1'b0);
    check("halt padOe", padOe, 8'h05);
    @(posedge mclk);
    {clkOutRun, idleWaitMode, haltMode} <= 3'h0;
    $display("test lowpower done");
  endtask

  // ----------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    give_verdict();
  end
  initial begin
    tick(2);
    t_reset();
    @(posedge mclk);
    resetn <= 1'b1;
    t_output();
    t_bidir();
    t_input();
    t_altfn();
    t_lowpower();
    give_verdict();
  end
endmodule
`default_nettype wire
